// ===== chamber_pressure_alarm_monitor.sv
/*
 chamber pressure alarm monitor with an apb register slave.
 assumes keys are debounced, synchronous to pclk and high while pressed;
 pressure samples arrive synchronous to pclk with a one-cycle valid.
 setpoints live in registers that software saves to and restores from
 non-volatile storage; hardware keeps them while presetn stays high.
*/
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module chamber_pressure_alarm_monitor #(
	parameter int unsigned tick_cycles = pressure_monitor_pkg::tick_cycles,
	parameter int unsigned warmup_ticks = pressure_monitor_pkg::warmup_ticks,
	parameter int unsigned mute_ticks = pressure_monitor_pkg::mute_ticks
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire pressure_monitor_pkg::keys_t     keys,
	input  wire logic signed [15:0]              pressure_raw,
	input  wire logic                            pressure_valid,
	output pressure_monitor_pkg::leds_t          leds,
	output pressure_monitor_pkg::display_t       display,
	output logic                                 buzzer,
	output pressure_monitor_pkg::relay_t         relay
);
	localparam logic signed [15:0] zero_p = 16'sd0;

	// every check in this block runs on pclk and rests while presetn is low
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	pressure_monitor_pkg::mode_t mode_q;
	logic [2:0]          ctrl_q;
	logic signed [15:0]  high_q, low_q, offset_q, edit_q, reading_q;
	logic [16:0]         tick_cnt_q;
	logic                tick;
	logic [31:0]         mode_cnt_q, hold_cnt_q, qual_cnt_q, door_cnt_q;
	logic [31:0]         ring_cnt_q, mute_cnt_q, blink_cnt_q;
	logic                blink_q, alarm_q, muted_q, door_alarm_q;
	logic [1:0]          held_q;
	logic                key_reset_q;
	logic                running, beyond, near, at_zero, key_reset_rise;
	logic                wr, rd;

	// round to display steps of 0.01 (two lsb)
	function automatic logic signed [15:0] to_display(
		input logic signed [15:0] v);
		to_display = v & ~16'sd1;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign tick = (tick_cnt_q == 17'(tick_cycles - 1));
	assign running = (mode_q == pressure_monitor_pkg::st_run);
	// corrected reading against the limits
	assign beyond = (reading_q >= high_q) || (reading_q <= low_q);
	assign near = (reading_q >= high_q - pressure_monitor_pkg::caution_band)
		|| (reading_q <= low_q + pressure_monitor_pkg::caution_band);
	assign at_zero = (reading_q >= zero_p);
	assign key_reset_rise = keys.reset && !key_reset_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 17'h0;
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
			key_reset_q <= 1'b0;
		end else begin
			key_reset_q <= keys.reset;
			tick_cnt_q <= tick ? 17'h0 : tick_cnt_q + 17'h1;
			if (tick) begin
				if (blink_cnt_q == pressure_monitor_pkg::blink_ticks - 1) begin
					blink_cnt_q <= 32'h0;
					blink_q <= !blink_q;
				end else begin
					blink_cnt_q <= blink_cnt_q + 32'h1;
				end
			end
		end
	end

	// apb registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 3'h0;
			prdata <= 32'h0;
		end else begin
			if (wr && paddr == pressure_monitor_pkg::reg_ctrl)
				ctrl_q <= pwdata[2:0];
			if (rd) begin
				case (paddr)
				pressure_monitor_pkg::reg_ctrl:
					prdata <= {29'h0, ctrl_q};
				pressure_monitor_pkg::reg_status:
					prdata <= {16'h0, 9'h0, mode_q};
				pressure_monitor_pkg::reg_high:
					prdata <= {{16{high_q[15]}}, high_q};
				pressure_monitor_pkg::reg_low:
					prdata <= {{16{low_q[15]}}, low_q};
				pressure_monitor_pkg::reg_offset:
					prdata <= {{16{offset_q[15]}}, offset_q};
				pressure_monitor_pkg::reg_display:
					prdata <= {{16{reading_q[15]}}, reading_q};
				default:
					prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reading_q <= 16'sd0;
		end else if (pressure_valid) begin
			reading_q <= pressure_raw + offset_q;
		end
	end

	// operating mode and calibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= pressure_monitor_pkg::st_off;
			mode_cnt_q <= 32'h0;
			hold_cnt_q <= 32'h0;
			held_q <= 2'b00;
			edit_q <= 16'sd0;
			high_q <= pressure_monitor_pkg::high_default;
			low_q <= pressure_monitor_pkg::low_default;
			offset_q <= pressure_monitor_pkg::offset_default;
		end else begin
			// retained values restored by software after power loss
			if (wr && paddr == pressure_monitor_pkg::reg_high)
				high_q <= pwdata[15:0];
			if (wr && paddr == pressure_monitor_pkg::reg_low)
				low_q <= pwdata[15:0];
			if (wr && paddr == pressure_monitor_pkg::reg_offset)
				offset_q <= pwdata[15:0];
			if (tick)
				mode_cnt_q <= mode_cnt_q + 32'h1;
			held_q <= {keys.up, keys.down};
			if (tick && {keys.up, keys.down} == held_q && held_q != 2'b00)
				hold_cnt_q <= hold_cnt_q + 32'h1;
			else if ({keys.up, keys.down} != held_q)
				hold_cnt_q <= 32'h0;
			case (mode_q)
			pressure_monitor_pkg::st_off: begin
				mode_cnt_q <= 32'h0;
				if (ctrl_q[pressure_monitor_pkg::ctrl_blower]
					|| ctrl_q[pressure_monitor_pkg::ctrl_exhaust])
					mode_q <= pressure_monitor_pkg::st_selftest;
			end
			pressure_monitor_pkg::st_selftest: begin
				if (mode_cnt_q >= pressure_monitor_pkg::selftest_ticks) begin
					mode_q <= pressure_monitor_pkg::st_warmup;
					mode_cnt_q <= 32'h0;
				end
			end
			pressure_monitor_pkg::st_warmup: begin
				if (mode_cnt_q >= warmup_ticks)
					mode_q <= pressure_monitor_pkg::st_run;
			end
			pressure_monitor_pkg::st_run: begin
				if (hold_cnt_q >= pressure_monitor_pkg::hold_ticks) begin
					hold_cnt_q <= 32'h0;
					case (held_q)
					2'b11: begin
						mode_q <= pressure_monitor_pkg::st_cal_nom;
						edit_q <= reading_q;
					end
					2'b10: begin
						mode_q <= pressure_monitor_pkg::st_cal_high;
						edit_q <= high_q;
					end
					default: begin
						mode_q <= pressure_monitor_pkg::st_cal_low;
						edit_q <= low_q;
					end
					endcase
				end
			end
			pressure_monitor_pkg::st_cal_nom,
			pressure_monitor_pkg::st_cal_high,
			pressure_monitor_pkg::st_cal_low: begin
				if (keys.up && !held_q[1])
					edit_q <= edit_q + pressure_monitor_pkg::cal_step;
				else if (keys.down && !held_q[0])
					edit_q <= edit_q - pressure_monitor_pkg::cal_step;
				if (key_reset_rise) begin
					mode_q <= pressure_monitor_pkg::st_run;
					if (mode_q == pressure_monitor_pkg::st_cal_nom)
						offset_q <= offset_q + edit_q - reading_q;
					else if (mode_q == pressure_monitor_pkg::st_cal_high)
						high_q <= edit_q;
					else
						low_q <= edit_q;
				end
			end
			default: mode_q <= pressure_monitor_pkg::st_off;
			endcase
			if (!ctrl_q[pressure_monitor_pkg::ctrl_blower]
				&& !ctrl_q[pressure_monitor_pkg::ctrl_exhaust])
				mode_q <= pressure_monitor_pkg::st_off;
		end
	end

	// alarm qualification, door delay and buzzer cadence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qual_cnt_q <= 32'h0;
			door_cnt_q <= 32'h0;
			ring_cnt_q <= 32'h0;
			mute_cnt_q <= 32'h0;
			alarm_q <= 1'b0;
			muted_q <= 1'b0;
			door_alarm_q <= 1'b0;
		end else if (!running || !beyond) begin
			qual_cnt_q <= 32'h0;
			door_cnt_q <= 32'h0;
			ring_cnt_q <= 32'h0;
			mute_cnt_q <= 32'h0;
			alarm_q <= 1'b0;
			muted_q <= 1'b0;
			door_alarm_q <= 1'b0;
		end else begin
			if (tick) begin
				if (qual_cnt_q < pressure_monitor_pkg::qualify_ticks)
					qual_cnt_q <= qual_cnt_q + 32'h1;
				else
					alarm_q <= 1'b1;
				if (at_zero && door_cnt_q <= pressure_monitor_pkg::door_ticks)
					door_cnt_q <= door_cnt_q + 32'h1;
				door_alarm_q <= !at_zero
					|| door_cnt_q > pressure_monitor_pkg::door_ticks;
				if (alarm_q) begin
					if (ring_cnt_q == pressure_monitor_pkg::ring_first_ticks
						+ pressure_monitor_pkg::ring_period_ticks - 1)
						ring_cnt_q <= pressure_monitor_pkg::ring_first_ticks;
					else
						ring_cnt_q <= ring_cnt_q + 32'h1;
				end
				if (muted_q) begin
					if (mute_cnt_q >= mute_ticks) begin
						muted_q <= 1'b0;
						ring_cnt_q <= pressure_monitor_pkg::ring_first_ticks;
					end else begin
						mute_cnt_q <= mute_cnt_q + 32'h1;
					end
				end
			end
			// a key press in the cycle the mute runs out starts a new mute
			if (alarm_q && key_reset_rise) begin
				muted_q <= 1'b1;
				mute_cnt_q <= 32'h0;
			end
		end
	end

	// outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			leds <= '0;
			display <= '0;
			buzzer <= 1'b0;
			relay <= '0;
		end else begin
			display <= '0;
			leds <= '0;
			buzzer <= 1'b0;
			case (mode_q)
			pressure_monitor_pkg::st_selftest: begin
				leds <= 3'b111;
				display.all_segments <= 1'b1;
				buzzer <= 1'b1;
			end
			pressure_monitor_pkg::st_warmup: begin
				display.dashes <= 1'b1;
				leds.green <= blink_q;
			end
			pressure_monitor_pkg::st_run: begin
				display.value <= to_display(reading_q);
				if (beyond && at_zero)
					display.value <= to_display(high_q);
				leds.red <= alarm_q || beyond;
				leds.yellow <= near && !beyond;
				leds.green <= !near;
				buzzer <= alarm_q && door_alarm_q && !muted_q
					&& ring_cnt_q < pressure_monitor_pkg::ring_first_ticks
					+ pressure_monitor_pkg::ring_on_ticks;
			end
			pressure_monitor_pkg::st_cal_nom,
			pressure_monitor_pkg::st_cal_high,
			pressure_monitor_pkg::st_cal_low: begin
				leds.red <= blink_q;
				display.prompt_nominal <= blink_q
					&& mode_q == pressure_monitor_pkg::st_cal_nom;
				display.upper_bound_prompt <= blink_q
					&& mode_q == pressure_monitor_pkg::st_cal_high;
				display.bottom_bound_prompt <= blink_q
					&& mode_q == pressure_monitor_pkg::st_cal_low;
				display.value <= to_display(edit_q);
			end
			default: ;
			endcase
			if (ctrl_q[pressure_monitor_pkg::ctrl_fault]
				&& mode_q != pressure_monitor_pkg::st_off)
				leds <= {3{blink_q}};
			relay.com_no_closed <= running && alarm_q;
			relay.com_nc_closed <= !(running && alarm_q)
				&& !ctrl_q[pressure_monitor_pkg::ctrl_exhaust];
		end
	end

	a_reset_mutes: assert property (
		running && beyond && alarm_q && key_reset_rise |=> ##1 !buzzer)
		else $error("buzzer sounds after mute");
	a_clear_alarm: assert property (!beyond |=> !alarm_q)
		else $error("alarm kept after recovery");
	a_relay_exclusive: assert property (
		!(relay.com_no_closed && relay.com_nc_closed))
		else $error("both relay contacts closed");
	a_exhaust_no_nc: assert property (
		$past(ctrl_q[pressure_monitor_pkg::ctrl_exhaust])
		|-> !relay.com_nc_closed)
		else $error("nc contact on exhaust variant");
	a_alarm_qualify: assert property (
		$rose(alarm_q)
		|-> qual_cnt_q >= pressure_monitor_pkg::qualify_ticks)
		else $error("alarm raised early");
	a_relay_follow: assert property (
		running && alarm_q |=> relay.com_no_closed)
		else $error("blower not cut in alarm");
	a_warmup_dash: assert property (
		mode_q == pressure_monitor_pkg::st_warmup |=> display.dashes)
		else $error("no dashes in warm-up");
	// a fault indication overrides the lamp test
	a_selftest_all: assert property (
		mode_q == pressure_monitor_pkg::st_selftest
		&& !ctrl_q[pressure_monitor_pkg::ctrl_fault]
		|=> leds == 3'b111 && buzzer)
		else $error("self-check incomplete");
endmodule
`default_nettype wire

// ===== pressure_monitor_pkg.sv
/*
 chamber pressure monitor: constants, modes and carrier structs.
 assumes a 100 MHz pclk; pressures are signed half-hundredths of an inch
 (0.005 in w.g. per lsb) carried as 16-bit two's complement.
*/
// What this block does
// - start when blower on; exhaust variant at power
// - start-up lights everything, short tone
// - warm-up shows dashes, green blinks
// - measure and display only after warm-up
// - malfunction blinks green, yellow, red together
// - display resolves 0.01 in w.g. steps
// - green ok, yellow near limit, red alarm
// - high setpoint -0.03, low -1.50 default
// - zero pressure: show high setpoint, pending, delay
// - zero beyond door delay sounds buzzer
// - both arrows held enter nominal calibration
// - arrows adjust offset to match gauge
// - reset key stores value, leaves calibration
// - single arrow held edits high/low setpoint
// - arrows adjust setpoint, reset key stores it
// - alarm only after five seconds beyond limit
// - back within limits clears alarm, silences
// - buzzer 30 s, then 1 s every 10 s
// - reset key mutes five minutes, ring-back resumes
// - changeover relay contacts follow alarm
// - no/com pair cuts blower power in alarm
// - exhaust variant has no normally closed contact
package pressure_monitor_pkg;
	localparam int unsigned clk_hz = 100_000_000;
	localparam int unsigned ms_per_s = 1000;
	// time figures in their own units
	localparam int unsigned selftest_ms = 1000;
	localparam int unsigned warmup_s = 240;
	localparam int unsigned door_delay_s = 60;
	localparam int unsigned hold_s = 3;
	localparam int unsigned qualify_s = 5;
	localparam int unsigned ring_first_s = 30;
	localparam int unsigned ring_on_s = 1;
	localparam int unsigned ring_period_s = 10;
	localparam int unsigned mute_s = 300;
	localparam int unsigned blink_ms = 500;
	// one millisecond tick; every longer time is counted in ticks
	localparam int unsigned tick_cycles = clk_hz / ms_per_s;
	localparam int unsigned selftest_ticks = selftest_ms;
	localparam int unsigned warmup_ticks = warmup_s * ms_per_s;
	localparam int unsigned door_ticks = door_delay_s * ms_per_s;
	localparam int unsigned hold_ticks = hold_s * ms_per_s;
	localparam int unsigned qualify_ticks = qualify_s * ms_per_s;
	localparam int unsigned ring_first_ticks = ring_first_s * ms_per_s;
	localparam int unsigned ring_on_ticks = ring_on_s * ms_per_s;
	localparam int unsigned ring_period_ticks = ring_period_s * ms_per_s;
	localparam int unsigned mute_ticks = mute_s * ms_per_s;
	localparam int unsigned blink_ticks = blink_ms;
	// pressure scale: 1 lsb = 0.005 in w.g.
	localparam logic signed [15:0] high_default = -16'sd6;
	localparam logic signed [15:0] low_default = -16'sd300;
	localparam logic signed [15:0] offset_default = 16'sd0;
	localparam logic signed [15:0] caution_band = 16'sd1;
	localparam logic signed [15:0] cal_step = 16'sd2;
	// apb map
	localparam logic [11:0] reg_ctrl = 12'h000;
	localparam logic [11:0] reg_status = 12'h004;
	localparam logic [11:0] reg_high = 12'h008;
	localparam logic [11:0] reg_low = 12'h00c;
	localparam logic [11:0] reg_offset = 12'h010;
	localparam logic [11:0] reg_display = 12'h014;
	localparam int unsigned ctrl_blower = 0;
	localparam int unsigned ctrl_exhaust = 1;
	localparam int unsigned ctrl_fault = 2;

	typedef enum logic [6:0] {
		st_off      = 7'b0000001,
		st_selftest = 7'b0000010,
		st_warmup   = 7'b0000100,
		st_run      = 7'b0001000,
		st_cal_nom  = 7'b0010000,
		st_cal_high = 7'b0100000,
		st_cal_low  = 7'b1000000
	} mode_t;

	typedef struct packed {
		logic up;
		logic down;
		logic reset;
	} keys_t;

	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} leds_t;

	typedef struct packed {
		logic all_segments;
		logic dashes;
		logic prompt_nominal;
		logic upper_bound_prompt;
		logic bottom_bound_prompt;
		logic signed [15:0] value;
	} display_t;

	typedef struct packed {
		logic com_no_closed;
		logic com_nc_closed;
	} relay_t;
endpackage

// ===== keypad_transducer_model.sv
/*
 operator keypad and pressure transducer model.
 assumes the monitor's pclk and presetn; the bench sets level and keys.
*/
`timescale 1ns/1ps
`default_nettype none
module keypad_transducer_model #(
	parameter int unsigned period = 7
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic signed [15:0]          level,
	input  wire pressure_monitor_pkg::keys_t press,
	output pressure_monitor_pkg::keys_t      keys,
	output logic signed [15:0]               pressure_raw,
	output logic                             pressure_valid
);
	int unsigned cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			keys <= '0;
			pressure_valid <= 1'b0;
			pressure_raw <= 16'h0000;
		end else begin
			keys <= press; // held for as long as the operator holds
			cnt_q <= (cnt_q + 1 >= period) ? 0 : cnt_q + 1;
			pressure_valid <= (cnt_q == 0);
			// outside its pulse the sample bus carries no valid reading
			pressure_raw <= (cnt_q == 0) ? level : ~level;
		end
	end
endmodule
`default_nettype wire

// ===== chamber_pressure_alarm_monitor_tb_top.sv
/*
 self-checking bench for the chamber pressure alarm monitor.
 assumes short tick and warm-up parameters; registers reached over apb.
*/
`timescale 1ns/1ps
`default_nettype none
module chamber_pressure_alarm_monitor_tb_top;
	localparam int unsigned tk = 2;
	localparam int unsigned q_cyc = pressure_monitor_pkg::qualify_ticks * tk;
	localparam int unsigned h_cyc = pressure_monitor_pkg::hold_ticks * tk;
	localparam logic signed [15:0] hi = pressure_monitor_pkg::high_default;
	localparam logic signed [15:0] lo = pressure_monitor_pkg::low_default;
	localparam logic signed [15:0] p_ok = 16'hff9c;
	logic                           pclk = 1'b0;
	logic                           presetn = 1'b0;
	logic                           psel = 1'b0;
	logic                           penable = 1'b0;
	logic                           pwrite = 1'b0;
	logic [11:0]                    paddr = 12'h000;
	logic [31:0]                    pwdata = 32'h0;
	logic [31:0]                    prdata;
	logic                           pready;
	logic                           pslverr;
	pressure_monitor_pkg::keys_t    keys;
	pressure_monitor_pkg::keys_t    press = '0;
	logic signed [15:0]             level = 16'hff9c;
	logic signed [15:0]             pressure_raw;
	logic                           pressure_valid;
	pressure_monitor_pkg::leds_t    leds;
	pressure_monitor_pkg::display_t display;
	logic                           buzzer;
	pressure_monitor_pkg::relay_t   relay;
	logic [31:0]                    seed = 32'h0000d2a8;
	int                             n_errors = 0;
	int                             n_tests = 0;

	always #5 pclk = ~pclk;

	chamber_pressure_alarm_monitor #(.tick_cycles(tk), .warmup_ticks(20),
		.mute_ticks(50)) u_chamber_pressure_alarm_monitor (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .keys(keys), .pressure_raw(pressure_raw),
		.pressure_valid(pressure_valid), .leds(leds), .display(display),
		.buzzer(buzzer), .relay(relay));

	keypad_transducer_model u_keypad_transducer_model (.pclk(pclk),
		.presetn(presetn), .level(level), .press(press), .keys(keys),
		.pressure_raw(pressure_raw), .pressure_valid(pressure_valid));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] sx(input logic signed [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] exp_leds(input logic signed [15:0] p);
		if (p >= hi || p <= lo)
			return 32'h1;
		if (p >= hi - pressure_monitor_pkg::caution_band ||
			p <= lo + pressure_monitor_pkg::caution_band)
			return 32'h2;
		return 32'h4;
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string what);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(what, r, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic wait_mode(input int b);
		logic [31:0] r;
		for (int k = 0; k < 2000; k++) begin
			apb(1'b0, pressure_monitor_pkg::reg_status, 32'h0, r);
			if (r[b] === 1'b1)
				break;
		end
	endtask

	task automatic set_p(input logic signed [15:0] v);
		level <= v;
		cyc(20);
	endtask

	task automatic tap(input logic [2:0] k);
		press <= k;
		cyc(4);
		press <= '0;
		cyc(6);
	endtask

	initial begin
		repeat (95000) @(posedge pclk);
		n_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		logic signed [15:0] v;
		logic signed [15:0] corner [4];
		logic [2:0] cm [3];
		int sb [3];
		int on;
		int off;
		int odd;
		int seen;
		corner = '{16'hfff9, 16'hfed5, hi, lo};
		cm = '{3'b110, 3'b100, 3'b010};
		sb = '{4, 5, 6};
		on = 0;
		off = 0;
		odd = 0;
		cyc(12);
		presetn <= 1'b1;
		rd(pressure_monitor_pkg::reg_high, sx(hi), "high");
		rd(pressure_monitor_pkg::reg_low, sx(lo), "low");
		rd(12'h0f0, 32'h0, "unmapped");
		rd(pressure_monitor_pkg::reg_status, 32'h1, "off");
		wr(pressure_monitor_pkg::reg_ctrl, 32'h1);
		cyc(10);
		chk("lamp test", 32'(leds), 32'h7);
		chk("segments", 32'(display.all_segments), 32'h1);
		chk("tone", 32'(buzzer), 32'h1);
		wait_mode(2);
		chk("dashes", 32'(display.dashes), 32'h1);
		wait_mode(3);
		rd(pressure_monitor_pkg::reg_status, 32'h8, "run");
		repeat (6) begin
			v = 16'h0000 - 16'(xs() % 200) - 16'h0032;
			set_p(v);
			chk("leds", 32'(leds), exp_leds(v));
			chk("value", sx(display.value), sx(v & 16'hfffe));
			rd(pressure_monitor_pkg::reg_display, sx(v), "read");
		end
		foreach (corner[i]) begin
			set_p(corner[i]);
			chk("edge leds", 32'(leds), exp_leds(corner[i]));
		end
		set_p(p_ok);
		set_p(hi);
		cyc(q_cyc - 1000);
		chk("short", 32'(buzzer), 32'h0);
		set_p(p_ok);
		set_p(hi);
		cyc(q_cyc + 200);
		chk("qualified", 32'(buzzer), 32'h1);
		chk("relay alarm", 32'(relay), 32'h2);
		cyc(2000);
		chk("steady", 32'(buzzer), 32'h1);
		set_p(p_ok);
		chk("cleared", 32'(buzzer), 32'h0);
		chk("relay ok", 32'(relay), 32'h1);
		set_p(lo);
		cyc(q_cyc + 200);
		chk("low alarm", 32'(buzzer), 32'h1);
		tap(3'b001);
		chk("muted", 32'(buzzer), 32'h0);
		cyc(150);
		chk("ring back", 32'(buzzer), 32'h1);
		set_p(p_ok);
		set_p(16'h0000);
		chk("door value", sx(display.value), sx(hi));
		cyc(q_cyc + 2000);
		chk("door delay", 32'(buzzer), 32'h0);
		set_p(p_ok);
		foreach (cm[i]) begin
			press <= cm[i];
			cyc(h_cyc + 400);
			rd(pressure_monitor_pkg::reg_status, 32'(1 << sb[i]), "cal");
			press <= '0;
			cyc(10);
			seen = 0;
			repeat (1100) begin
				@(posedge pclk);
				if (leds.red && {display.prompt_nominal,
					display.upper_bound_prompt,
					display.bottom_bound_prompt} == 3'(1 << (6 - sb[i])))
					seen++;
			end
			chk("prompt", 32'(seen > 0), 32'h1);
			tap(3'b010);
			tap(3'b001);
			rd(pressure_monitor_pkg::reg_status, 32'h8, "back");
		end
		rd(pressure_monitor_pkg::reg_offset, sx(16'hfffe), "offset");
		rd(pressure_monitor_pkg::reg_high, sx(hi - 16'h2), "new high");
		rd(pressure_monitor_pkg::reg_low, sx(lo - 16'h2), "new low");
		wr(pressure_monitor_pkg::reg_high, sx(hi));
		rd(pressure_monitor_pkg::reg_high, sx(hi), "kept");
		wr(pressure_monitor_pkg::reg_ctrl, 32'h5);
		cyc(2);
		repeat (2600) begin
			@(posedge pclk);
			if (leds === 3'b111)
				on++;
			else if (leds === 3'b000)
				off++;
			else
				odd++;
		end
		chk("fault blink", {29'h0, on > 0, off > 0, odd == 0}, 32'h7);
		wr(pressure_monitor_pkg::reg_ctrl, 32'h2);
		cyc(4);
		chk("exhaust nc", 32'(relay), 32'h0);
		rd(pressure_monitor_pkg::reg_status, 32'h8, "exhaust run");
		wr(pressure_monitor_pkg::reg_ctrl, 32'h0);
		rd(pressure_monitor_pkg::reg_status, 32'h1, "stopped");
		tally_and_finish();
	end
endmodule
`default_nettype wire
